// ---- design/pmtr_pkg.sv ----
package pmtr_pkg;

  // ****************************************************************
  // Memory geometry
  // ****************************************************************
  localparam int PM_WORD_W         = 16;
  localparam int PM_BYTE_W         = 8;
  localparam int PM_DEPTH_DEF      = 16384;
  localparam int PM_DEPTH_MIN      = 4096;
  localparam int PM_BANK_DEPTH_LIM = 8192;
  localparam int PM_BLOCK_WORDS    = 256;
  localparam int PM_PAGE_WORDS     = 64;

  localparam logic [15:0] PM_RESET_VECTOR = 16'h0000;
  localparam logic [15:0] PM_ERASED_WORD  = 16'hFFFF;

  // ****************************************************************
  // Data memory destination
  // ****************************************************************
  localparam int DM_ADDR_W     = 10;
  localparam int DM_SECTOR_LSB = 8;

  // ****************************************************************
  // Serial programming frame: command bit, address, data word
  // ****************************************************************
  localparam int PRG_HDR_BITS   = 16;
  localparam int PRG_FRAME_BITS = 32;
  localparam int PRG_CMD_POS    = 15;
  localparam int PRG_CNT_W      = 6;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    TR_NORMAL        = 2'b00,
    TR_NORMAL_LAST   = 2'b01,
    TR_EXTENDED      = 2'b10,
    TR_EXTENDED_LAST = 2'b11
  } pmtr_kind_type;

  typedef enum logic [1:0] {
    TRS_IDLE = 2'b00,
    TRS_READ = 2'b01,
    TRS_WB   = 2'b10
  } pmtr_state_type;

  function automatic logic kind_is_extended(input pmtr_kind_type k);
    return k[1];
  endfunction : kind_is_extended

  function automatic logic kind_is_last_page(input pmtr_kind_type k);
    return k[0];
  endfunction : kind_is_last_page

endpackage : pmtr_pkg

// ---- design/pmtr_mem_if.sv ----
`timescale 1ns/1ps
interface pmtr_mem_if import pmtr_pkg::*; #(
  parameter int ADDR_W = 14
) ();
  logic [ADDR_W-1:0]    fetch_addr;
  logic [PM_WORD_W-1:0] fetch_word;
  logic [ADDR_W-1:0]    rd_addr;
  logic [PM_WORD_W-1:0] rd_word;
  logic                 wr_en;
  logic [ADDR_W-1:0]    wr_addr;
  logic [PM_WORD_W-1:0] wr_word;

  modport ctrl (
    output fetch_addr, rd_addr, wr_en, wr_addr, wr_word,
    input  fetch_word, rd_word
  );
  modport mem (
    input  fetch_addr, rd_addr, wr_en, wr_addr, wr_word,
    output fetch_word, rd_word
  );
endinterface : pmtr_mem_if

// ---- design/pmtr_prog_mem.sv ----
`timescale 1ns/1ps
module pmtr_prog_mem import pmtr_pkg::*; #(
  parameter int DEPTH = PM_DEPTH_DEF
) (
  input wire logic   clk_i,
  input wire logic   reset_n_i,
  pmtr_mem_if.mem    bus
);
  // ****************************************************************
  // Banked word array
  // ****************************************************************
  localparam int ADDR_W    = $clog2(DEPTH);
  localparam int NUM_BANKS = (DEPTH > PM_BANK_DEPTH_LIM) ? 2 : 1;
  localparam int BANK_D    = DEPTH / NUM_BANKS;
  localparam int BANK_W    = $clog2(BANK_D);

  logic [PM_WORD_W-1:0] bank_mem [NUM_BANKS][BANK_D];

  function automatic int bank_of(input logic [ADDR_W-1:0] a);
    return (NUM_BANKS > 1) ? int'(a[ADDR_W-1]) : 0;
  endfunction : bank_of

  function automatic logic [BANK_W-1:0] offs_of(input logic [ADDR_W-1:0] a);
    return a[BANK_W-1:0];
  endfunction : offs_of

  always_ff @(posedge clk_i) begin
    if (bus.wr_en) begin
      bank_mem[bank_of(bus.wr_addr)][offs_of(bus.wr_addr)] <= bus.wr_word;
    end
  end

  // Read ports are registered so every word handed out comes from a flop
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      bus.fetch_word <= '0;
      bus.rd_word    <= '0;
    end else begin
      bus.fetch_word <= bank_mem[bank_of(bus.fetch_addr)]
                                [offs_of(bus.fetch_addr)];
      bus.rd_word    <= bank_mem[bank_of(bus.rd_addr)][offs_of(bus.rd_addr)];
    end
  end
endmodule : pmtr_prog_mem

// ---- design/pmtr_table_read.sv ----
// Contract
// - After reset, instruction fetch starts at program address zero.
// - Program memory holds 16-bit words, 4K to 16K deep, 16K in two banks.
// - Table address is the high pointer concatenated with the low pointer; last-page forms put all ones above the low pointer.
// - Low byte of the table word goes to the named data register.
// - High byte goes to the table-high latch; missing bits load as zero.
// - Every table read, normal or extended, takes exactly two cycles.
// - Software can read and write the table-high latch.
// - Normal forms write sector zero only; other sectors need extended forms.
// - Programming moves data both ways on one line against programmer clock.
// - Smallest configuration erases by blocks, others by pages.
`timescale 1ns/1ps
module pmtr_table_read import pmtr_pkg::*; #(
  parameter int DEPTH      = PM_DEPTH_DEF,
  parameter int PAGE_WORDS = PM_PAGE_WORDS,
  parameter int ADDR_W     = $clog2(DEPTH)
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 fetch_adv_i,
  input  wire logic                 fetch_load_i,
  input  wire logic [ADDR_W-1:0]    fetch_target_i,
  output wire logic [ADDR_W-1:0]    fetch_addr_o,
  output wire logic [PM_WORD_W-1:0] fetch_word_o,
  input  wire logic                 tr_req_i,
  input  wire pmtr_kind_type        tr_kind_i,
  input  wire logic [DM_ADDR_W-1:0] tr_dest_i,
  input  wire logic [PM_BYTE_W-1:0] tbl_ptr_lo_i,
  input  wire logic [PM_BYTE_W-1:0] tbl_ptr_hi_i,
  output wire logic                 tr_busy_o,
  output wire logic                 tr_done_o,
  output wire logic                 tr_sector_err_o,
  output wire logic                 dmem_we_o,
  output wire logic [DM_ADDR_W-1:0] dmem_addr_o,
  output wire logic [PM_BYTE_W-1:0] dmem_wdata_o,
  input  wire logic                 table_high_latch_we_i,
  input  wire logic [PM_BYTE_W-1:0] table_high_latch_wdata_i,
  output wire logic [PM_BYTE_W-1:0] table_high_latch_o,
  input  wire logic                 erase_req_i,
  input  wire logic [ADDR_W-1:0]    erase_addr_i,
  output wire logic                 erase_busy_o,
  input  wire logic                 prog_mode_i,
  input  wire logic                 prog_serial_clock_i,
  input  wire logic                 prog_serial_data_i,
  output wire logic                 prog_serial_data_o,
  output wire logic                 prog_serial_data_oe_o
);
  // ****************************************************************
  // Derived geometry
  // ****************************************************************
  localparam int HI_W       = ADDR_W - PM_BYTE_W;
  localparam int ERASE_UNIT = (DEPTH == PM_DEPTH_MIN) ?
                              PM_BLOCK_WORDS : PAGE_WORDS;
  localparam int UNIT_W     = $clog2(ERASE_UNIT);
  localparam logic [ADDR_W-1:0] UNIT_MASK = ADDR_W'(ERASE_UNIT - 1);
  localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(ERASE_UNIT - 1);
  localparam logic [PRG_CNT_W-1:0] CNT_HDR_LAST =
    PRG_CNT_W'(PRG_HDR_BITS - 1);
  localparam logic [PRG_CNT_W-1:0] CNT_HDR  = PRG_CNT_W'(PRG_HDR_BITS);
  localparam logic [PRG_CNT_W-1:0] CNT_LAST =
    PRG_CNT_W'(PRG_FRAME_BITS - 1);

  pmtr_mem_if #(.ADDR_W(ADDR_W)) mem_bus ();

  // Word width and banking live in the array module
  pmtr_prog_mem #(.DEPTH(DEPTH)) u_mem (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .bus       (mem_bus)
  );

  // ****************************************************************
  // Instruction fetch pointer
  // ****************************************************************
  logic [ADDR_W-1:0] fetch_pc_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fetch_pc_reg <= ADDR_W'(PM_RESET_VECTOR);
    end else if (fetch_load_i) begin
      fetch_pc_reg <= fetch_target_i;
    end else if (fetch_adv_i) begin
      fetch_pc_reg <= fetch_pc_reg + ADDR_W'(1);
    end
  end

  assign mem_bus.fetch_addr = fetch_pc_reg;
  assign fetch_addr_o       = fetch_pc_reg;
  assign fetch_word_o       = mem_bus.fetch_word;

  // ****************************************************************
  // Table read sequencer
  // ****************************************************************
  pmtr_state_type            state_reg, state_next;
  logic [ADDR_W-1:0]         tr_addr_reg;
  logic [DM_ADDR_W-1:0]      tr_dest_reg;
  logic                      sect_err_reg;
  logic [PM_BYTE_W-1:0]      table_high_latch_reg;
  logic                      er_busy_reg;

  wire logic                 tr_accept;
  wire logic [ADDR_W-1:0]    tr_addr_full;
  wire logic [ADDR_W-1:0]    tr_addr_last;
  wire logic [ADDR_W-1:0]    tr_addr_sel;
  wire logic                 tr_dest_sect0;
  wire logic                 tr_sect_bad;
  wire logic [PM_BYTE_W-1:0] hi_byte;

  // Erase and programming own the array, so reads wait behind them
  assign tr_accept = tr_req_i && state_reg == TRS_IDLE &&
                     !er_busy_reg && !prog_mode_i;
  assign tr_addr_full = ADDR_W'({tbl_ptr_hi_i, tbl_ptr_lo_i});
  assign tr_addr_last = {{HI_W{1'b1}}, tbl_ptr_lo_i};
  assign tr_addr_sel  = kind_is_last_page(tr_kind_i) ?
                        tr_addr_last : tr_addr_full;
  assign tr_dest_sect0 = tr_dest_i[DM_ADDR_W-1:DM_SECTOR_LSB] == '0;
  assign tr_sect_bad   = !kind_is_extended(tr_kind_i) &&
                         !tr_dest_sect0;
  // Word is narrower than two bytes on no current build, but pad anyway
  assign hi_byte = PM_BYTE_W'(mem_bus.rd_word[PM_WORD_W-1:PM_BYTE_W]);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TRS_IDLE: begin
        if (tr_accept) begin
          state_next = TRS_READ;
        end
      end
      TRS_READ: begin
        state_next = TRS_WB;
      end
      TRS_WB: begin
        state_next = TRS_IDLE;
      end
      default: begin
        state_next = TRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_reg    <= TRS_IDLE;
      tr_addr_reg  <= '0;
      tr_dest_reg  <= '0;
      sect_err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (tr_accept) begin
        tr_addr_reg  <= tr_addr_sel;
        tr_dest_reg  <= tr_dest_i;
        sect_err_reg <= tr_sect_bad;
      end
    end
  end

  // A table read completing without a sector error wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      table_high_latch_reg <= '0;
    end else if (state_reg == TRS_WB && !sect_err_reg) begin
      table_high_latch_reg <= hi_byte;
    end else if (table_high_latch_we_i) begin
      table_high_latch_reg <= table_high_latch_wdata_i;
    end
  end

  assign tr_busy_o          = state_reg != TRS_IDLE || er_busy_reg ||
                              prog_mode_i;
  assign tr_done_o          = state_reg == TRS_WB;
  assign tr_sector_err_o    = state_reg == TRS_WB && sect_err_reg;
  assign dmem_we_o          = state_reg == TRS_WB && !sect_err_reg;
  assign dmem_addr_o        = tr_dest_reg;
  assign dmem_wdata_o       = mem_bus.rd_word[PM_BYTE_W-1:0];
  assign table_high_latch_o = table_high_latch_reg;

  // ****************************************************************
  // Self-update erase walker
  // ****************************************************************
  logic [ADDR_W-1:0] er_base_reg;
  logic [UNIT_W-1:0] er_cnt_reg;
  wire logic         er_start;
  wire logic [ADDR_W-1:0] er_addr;

  assign er_start = erase_req_i && !er_busy_reg && !prog_mode_i &&
                    state_reg == TRS_IDLE;
  assign er_addr  = er_base_reg | ADDR_W'(er_cnt_reg);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      er_busy_reg <= 1'b0;
      er_base_reg <= '0;
      er_cnt_reg  <= '0;
    end else if (er_start) begin
      er_busy_reg <= 1'b1;
      er_base_reg <= erase_addr_i & ~UNIT_MASK;
      er_cnt_reg  <= '0;
    end else if (er_busy_reg) begin
      er_cnt_reg  <= er_cnt_reg + UNIT_W'(1);
      er_busy_reg <= er_cnt_reg != UNIT_LAST;
    end
  end

  assign erase_busy_o = er_busy_reg;

  // ****************************************************************
  // Serial programming port
  // ****************************************************************
  logic                  pck_s1_reg, pck_s2_reg, pck_s3_reg;
  logic                  pck_lvl_reg, pck_prev_reg;
  logic                  pda_s1_reg, pda_s2_reg, pda_s3_reg, pda_lvl_reg;
  logic [PRG_CNT_W-1:0]  prg_cnt_reg;
  logic [PM_WORD_W-1:0]  prg_hdr_reg;
  logic [PM_WORD_W-1:0]  prg_shift_reg;
  logic [PM_WORD_W-1:0]  prg_out_reg;
  logic                  prg_oe_reg;
  logic                  prg_wr_reg;
  wire logic             pck_rise;
  wire logic             pck_fall;
  wire logic             prg_is_write;
  wire logic [ADDR_W-1:0] prg_addr;

  // A pin change is believed once two late stages agree
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pck_s1_reg   <= 1'b0;
      pck_s2_reg   <= 1'b0;
      pck_s3_reg   <= 1'b0;
      pck_lvl_reg  <= 1'b0;
      pck_prev_reg <= 1'b0;
      pda_s1_reg   <= 1'b0;
      pda_s2_reg   <= 1'b0;
      pda_s3_reg   <= 1'b0;
      pda_lvl_reg  <= 1'b0;
    end else begin
      pck_s1_reg   <= prog_serial_clock_i;
      pck_s2_reg   <= pck_s1_reg;
      pck_s3_reg   <= pck_s2_reg;
      pck_prev_reg <= pck_lvl_reg;
      pda_s1_reg   <= prog_serial_data_i;
      pda_s2_reg   <= pda_s1_reg;
      pda_s3_reg   <= pda_s2_reg;
      if (pck_s2_reg == pck_s3_reg) begin
        pck_lvl_reg <= pck_s3_reg;
      end
      if (pda_s2_reg == pda_s3_reg) begin
        pda_lvl_reg <= pda_s3_reg;
      end
    end
  end

  assign pck_rise     = pck_lvl_reg && !pck_prev_reg;
  assign pck_fall     = !pck_lvl_reg && pck_prev_reg;
  assign prg_is_write = prg_hdr_reg[PRG_CMD_POS];
  assign prg_addr     = prg_hdr_reg[ADDR_W-1:0];

  // Programmer samples on rising edges, device launches on falling ones
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !prog_mode_i) begin
      prg_cnt_reg   <= '0;
      prg_hdr_reg   <= '0;
      prg_shift_reg <= '0;
      prg_out_reg   <= '0;
      prg_oe_reg    <= 1'b0;
      prg_wr_reg    <= 1'b0;
    end else begin
      prg_wr_reg <= 1'b0;
      if (pck_rise) begin
        prg_shift_reg <= {prg_shift_reg[PM_WORD_W-2:0], pda_lvl_reg};
        prg_cnt_reg   <= prg_cnt_reg + PRG_CNT_W'(1);
        if (prg_cnt_reg == CNT_HDR_LAST) begin
          prg_hdr_reg <= {prg_shift_reg[PM_WORD_W-2:0], pda_lvl_reg};
        end
        if (prg_cnt_reg == CNT_LAST) begin
          prg_cnt_reg <= '0;
          prg_oe_reg  <= 1'b0;
          prg_wr_reg  <= prg_is_write;
        end
      end else if (pck_fall && prg_cnt_reg >= CNT_HDR && !prg_is_write) begin
        prg_oe_reg <= 1'b1;
        if (prg_cnt_reg == CNT_HDR) begin
          prg_out_reg <= mem_bus.rd_word;
        end else begin
          prg_out_reg <= {prg_out_reg[PM_WORD_W-2:0], 1'b0};
        end
      end
    end
  end

  assign prog_serial_data_o    = prg_out_reg[PM_WORD_W-1];
  assign prog_serial_data_oe_o = prg_oe_reg;

  // ****************************************************************
  // Array port selection
  // ****************************************************************
  // A programming write arriving during an erase is dropped
  assign mem_bus.rd_addr = prog_mode_i ? prg_addr : tr_addr_reg;
  assign mem_bus.wr_en   = er_busy_reg || prg_wr_reg;
  assign mem_bus.wr_addr = er_busy_reg ? er_addr : prg_addr;
  assign mem_bus.wr_word = er_busy_reg ? PM_ERASED_WORD : prg_shift_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_tr_take;
    tr_accept;
  endsequence

  sequence s_tr_finish;
    !tr_done_o ##1 tr_done_o;
  endsequence

  a_reset_fetch_zero: assert property (
    $past(!reset_n_i) |-> fetch_addr_o == ADDR_W'(PM_RESET_VECTOR))
    else $error("fetch did not start at the reset vector");

  a_two_cycle_read: assert property (
    s_tr_take |-> ##1 s_tr_finish ##1 !tr_done_o)
    else $error("table read did not take two cycles");

  a_table_addr_join: assert property (
    s_tr_take and tr_kind_i == TR_NORMAL |=>
      tr_addr_reg == ADDR_W'({$past(tbl_ptr_hi_i), $past(tbl_ptr_lo_i)}))
    else $error("table address not formed from both pointers");

  a_last_page_addr: assert property (
    s_tr_take and kind_is_last_page(tr_kind_i) |=>
      tr_addr_reg[ADDR_W-1:PM_BYTE_W] == '1 &&
      tr_addr_reg[PM_BYTE_W-1:0] == $past(tbl_ptr_lo_i))
    else $error("last page read used wrong address");

  a_low_byte_dest: assert property (
    s_tr_take ##2 !sect_err_reg |->
      dmem_we_o && dmem_addr_o == $past(tr_dest_i, 2))
    else $error("low byte not written to its destination");

  a_sector_guard: assert property (
    s_tr_take and tr_sect_bad |-> ##2 (tr_sector_err_o && !dmem_we_o))
    else $error("normal form wrote outside sector zero");

  a_high_latch_load: assert property (
    dmem_we_o |=> table_high_latch_o == $past(hi_byte))
    else $error("table-high latch missed the high byte");

  a_soft_latch_write: assert property (
    table_high_latch_we_i && !dmem_we_o |=> table_high_latch_o == $past(table_high_latch_wdata_i))
    else $error("software write to table-high latch lost");

  a_erase_in_unit: assert property (
    er_busy_reg |-> (mem_bus.wr_addr & ~UNIT_MASK) == er_base_reg)
    else $error("erase stepped outside its unit");

  a_serial_drive: assert property (
    prog_serial_data_oe_o |-> prog_mode_i && !prg_is_write &&
      prg_cnt_reg >= CNT_HDR)
    else $error("serial data driven outside a read phase");

endmodule : pmtr_table_read

// ---- bench/pmtr_prog_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Serial programmer model
// ****************************************************************
module pmtr_prog_model import pmtr_pkg::*; #(
  parameter int AW   = 12,
  parameter int HALF = 8
) (
  input  wire logic clk_i,
  input  wire logic dev_data_i,
  input  wire logic dev_oe_i,
  output logic      sclk_o,
  output wire logic line_o
);
  logic drv_en  = 1'b0;
  logic drv_val = 1'b0;
  logic noise   = 1'b0;
  int   fights  = 0;

  initial sclk_o = 1'b0;

  // Released line wanders so a stale level never passes for data
  always @(posedge clk_i) begin
    noise <= ~noise;
    if (drv_en && dev_oe_i) fights <= fights + 1;
  end

  assign line_o = dev_oe_i ? dev_data_i : (drv_en ? drv_val : noise);

  // Clock idles low between frames; each level held HALF cycles
  task automatic bit_cycle(input logic en, b, output logic s);
    drv_en  = en;
    drv_val = b;
    repeat (HALF) @(negedge clk_i);
    sclk_o = 1'b1;
    s      = line_o;
    repeat (HALF) @(negedge clk_i);
    sclk_o = 1'b0;
  endtask : bit_cycle

  task automatic frame(input logic wr, input logic [AW-1:0] a,
                       input logic [15:0] d, output logic [15:0] q);
    logic [15:0] hdr;
    logic        s;
    hdr              = 16'h0;
    hdr[PRG_CMD_POS] = wr;
    hdr[AW-1:0]      = a;
    for (int i = 15; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(wr, d[i], s);
      q[i] = s;
    end
    drv_en = 1'b0;
    repeat (2 * HALF) @(negedge clk_i);
  endtask : frame
endmodule : pmtr_prog_model

// ---- bench/pmtr_table_read_test.sv ----
`timescale 1ns/1ps
module pmtr_table_read_test import pmtr_pkg::*;;
  localparam int AW = 12;
  logic          clk_i = 1'b0, reset_n_i = 1'b0;
  logic          fetch_adv_i = 1'b0, fetch_load_i = 1'b0, tr_req_i = 1'b0;
  logic          table_high_latch_we_i = 1'b0, erase_req_i = 1'b0, prog_mode_i = 1'b0;
  logic          prog_serial_clock_i, prog_serial_data_i;
  logic          prog_serial_data_o, prog_serial_data_oe_o;
  logic          tr_busy_o, tr_done_o, tr_sector_err_o, dmem_we_o;
  logic          erase_busy_o;
  logic [AW-1:0] fetch_target_i = 12'h0, erase_addr_i = 12'h0;
  logic [AW-1:0] fetch_addr_o;
  logic [15:0]   fetch_word_o;
  pmtr_kind_type tr_kind_i = TR_NORMAL;
  logic [9:0]    tr_dest_i = 10'h0, dmem_addr_o;
  logic [7:0]    tbl_ptr_lo_i = 8'h0, tbl_ptr_hi_i = 8'h0, dmem_wdata_o;
  logic [7:0]    table_high_latch_wdata_i = 8'h0, table_high_latch_o, exp_latch = 8'h0;
  int            mismatches = 0, num_checks = 0, cycles = 0;
  logic [AW-1:0] pa [8] = '{12'h000, 12'h001, 12'h3C7, 12'h3C8,
                            12'hF06, 12'hF05, 12'h5FF, 12'hFFF};
  logic [15:0]   pd [8] = '{16'h2A5C, 16'h1234, 16'hB3E1, 16'h00FE,
                            16'h001A, 16'h8F0F, 16'h7711, 16'hC0DE};

  pmtr_table_read #(.DEPTH(4096)) i_dut (.clk_i, .reset_n_i, .fetch_adv_i,
    .fetch_load_i, .fetch_target_i, .fetch_addr_o, .fetch_word_o, .tr_req_i,
    .tr_kind_i, .tr_dest_i, .tbl_ptr_lo_i, .tbl_ptr_hi_i, .tr_busy_o,
    .tr_done_o, .tr_sector_err_o, .dmem_we_o, .dmem_addr_o, .dmem_wdata_o,
    .table_high_latch_we_i, .table_high_latch_wdata_i, .table_high_latch_o, .erase_req_i,
    .erase_addr_i, .erase_busy_o, .prog_mode_i, .prog_serial_clock_i,
    .prog_serial_data_i, .prog_serial_data_o, .prog_serial_data_oe_o);

  pmtr_prog_model #(.AW(AW)) i_prog (.clk_i, .dev_data_i(prog_serial_data_o),
    .dev_oe_i(prog_serial_data_oe_o), .sclk_o(prog_serial_clock_i),
    .line_o(prog_serial_data_i));

  // ****************************************************************
  // Clock, watchdog and reporting
  // ****************************************************************
  always #2.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reset_dut();
    reset_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    reset_n_i = 1'b1;
    exp_latch = 8'h0;
  endtask : reset_dut

  // Caller sits at a falling edge; the sequencer takes a new request
  // only from idle, so the task returns one cycle after the done cycle
  task automatic tbl_read(input pmtr_kind_type k, input logic [9:0] d,
                          input logic [7:0] lo, hi, input logic [15:0] w,
                          input logic err, sw);
    tr_req_i     = 1'b1;
    tr_kind_i    = k;
    tr_dest_i    = d;
    tbl_ptr_lo_i = lo;
    tbl_ptr_hi_i = hi;
    @(negedge clk_i);
    tr_req_i  = 1'b0;
    table_high_latch_we_i = 1'b0;
    chk("latch", exp_latch, table_high_latch_o);
    chk("busy", 16'h1, tr_busy_o);
    chk("done_early", 16'h0, tr_done_o);
    @(negedge clk_i);
    chk("done", 16'h1, tr_done_o);
    chk("sector_err", err, tr_sector_err_o);
    chk("dmem_we", !err, dmem_we_o);
    if (!err) begin
      chk("dmem_addr", d, dmem_addr_o);
      chk("dmem_data", w[7:0], dmem_wdata_o);
      exp_latch = w[15:8];
    end
    if (sw) begin
      table_high_latch_we_i    = 1'b1;
      table_high_latch_wdata_i = 8'hA5;
    end
    @(negedge clk_i);
    table_high_latch_we_i = 1'b0;
    chk("latch_load", exp_latch, table_high_latch_o);
  endtask : tbl_read

  task automatic settle();
    @(negedge clk_i);
    table_high_latch_we_i = 1'b0;
    chk("latch", exp_latch, table_high_latch_o);
  endtask : settle

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    reset_dut();
    chk("fetch_addr", 16'h0, fetch_addr_o);
    chk("erase_busy", 16'h0, erase_busy_o);
    fetch_adv_i = 1'b1;
    repeat (3) @(negedge clk_i);
    fetch_adv_i = 1'b0;
    chk("fetch_adv", 16'h3, fetch_addr_o);
    reset_dut();
    chk("fetch_rst", 16'h0, fetch_addr_o);
    chk("latch_rst", 16'h0, table_high_latch_o);
  endtask : t_reset

  task automatic t_program();
    logic [15:0] q;
    prog_mode_i = 1'b1;
    @(negedge clk_i);
    chk("busy_prog", 16'h1, tr_busy_o);
    for (int i = 0; i < 8; i++) i_prog.frame(1'b1, pa[i], pd[i], q);
    for (int i = 2; i < 8; i += 5) begin
      i_prog.frame(1'b0, pa[i], 16'h0, q);
      chk("serial_read", pd[i], q);
    end
    chk("line_fights", 16'h0, 16'(i_prog.fights));
    prog_mode_i = 1'b0;
    @(negedge clk_i);
  endtask : t_program

  task automatic t_fetch();
    chk("fetch_vec", pd[0], fetch_word_o);
    fetch_adv_i = 1'b1;
    @(negedge clk_i);
    fetch_adv_i = 1'b0;
    @(negedge clk_i);
    chk("fetch_next", pd[1], fetch_word_o);
    fetch_target_i = 12'hFFF;
    fetch_load_i   = 1'b1;
    fetch_adv_i    = 1'b1;
    @(negedge clk_i);
    fetch_load_i = 1'b0;
    fetch_adv_i  = 1'b0;
    chk("fetch_load", 16'hFFF, fetch_addr_o);
    @(negedge clk_i);
    chk("fetch_top", pd[7], fetch_word_o);
  endtask : t_fetch

  task automatic t_reads();
    tbl_read(TR_NORMAL, 10'h0A5, 8'hC7, 8'hF3, pd[2], 0, 0);
    tbl_read(TR_EXTENDED, 10'h2B0, 8'hC8, 8'hF3, pd[3], 0, 0);
    tbl_read(TR_NORMAL, 10'h140, 8'hC7, 8'h03, pd[2], 1, 0);
    tbl_read(TR_NORMAL_LAST, 10'h011, 8'h06, 8'h5A, pd[4], 0, 0);
    tbl_read(TR_EXTENDED_LAST, 10'h3FF, 8'h05, 8'h00, pd[5], 0, 1);
    settle();
    table_high_latch_we_i    = 1'b1;
    table_high_latch_wdata_i = 8'h3C;
    exp_latch    = 8'h3C;
    settle();
  endtask : t_reads

  task automatic t_erase();
    int n;
    n            = 0;
    erase_req_i  = 1'b1;
    erase_addr_i = 12'h5A0;
    @(negedge clk_i);
    erase_req_i = 1'b0;
    tr_req_i    = 1'b1;
    repeat (4) begin
      chk("busy_erase", 16'h1, tr_busy_o);
      @(negedge clk_i);
      chk("refused", 16'h0, tr_done_o);
      n++;
    end
    tr_req_i = 1'b0;
    while (erase_busy_o === 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    chk("erase_len", 16'h100, 16'(n));
    tbl_read(TR_NORMAL, 10'h020, 8'hFF, 8'h05, 16'hFFFF, 0, 0);
    tbl_read(TR_NORMAL, 10'h021, 8'hC7, 8'h03, pd[2], 0, 0);
    settle();
  endtask : t_erase

  initial begin
    t_reset();
    t_program();
    t_fetch();
    t_reads();
    t_erase();
    conclude();
  end
endmodule : pmtr_table_read_test
